// *** rtl/lsp_pkg.sv ***
// shared constants and carrier types for the led select and peripheral pin block
package lsp_pkg;
    // core clock
    localparam int CLK_HZ = 10_000_000;
    // led colour select encodings
    localparam logic [1:0] LED_NONE = 2'h0;
    localparam logic [1:0] LED_RED = 2'h1;
    localparam logic [1:0] LED_GREEN = 2'h2;
    localparam logic [1:0] LED_BLUE = 2'h3;
    // host notification levels
    localparam logic NOTIFY_BUSY = 1'h1;
    localparam logic NOTIFY_DONE = 1'h0;
    // serial port: last divider count of each two-cycle half period of the serial clock
    localparam logic [1:0] SPI_HALF_LAST = 2'h1;
    localparam logic [2:0] SPI_MSB = 3'h7;
    // boot read from flash during auto-initialisation
    localparam logic [7:0] FLASH_READ_CMD = 8'h03;
    localparam logic [4:0] FLASH_ADDR_BYTES = 5'h03;
    localparam logic [4:0] INIT_LEN = 5'h10;
    localparam logic [4:0] INIT_LAST = FLASH_ADDR_BYTES + INIT_LEN;
    // successive approximation converter
    localparam logic [2:0] ADC_MSB = 3'h7;
    localparam logic [7:0] ADC_FIRST_TRIAL = 8'h80;
    localparam logic [7:0] PWM_LAST = 8'hff;
    localparam logic [1:0] ADC_SETTLE_LAST = 2'h3;

    // serial port 0 pins, all outputs
    typedef struct packed {
        logic sclk;
        logic mosi;
        logic cs0_n;
        logic cs1_n;
    } lsp_spi_pins_t;

    // sampled control port lines
    typedef struct packed {
        logic scl;
        logic sda;
    } lsp_i2c_lines_t;
endpackage

// *** rtl/lsp_spi_shift.sv ***
// serial port 0 byte shifter, mode 0, two active-low selects
`timescale 1ns/10ps
`default_nettype none
module lsp_spi_shift
    import lsp_pkg::*;
(
    input wire logic sys_clk_i,           // core clock
    input wire logic resetn_i,            // sync reset, active low
    input wire logic start_i,             // begin one byte, taken when idle
    input wire logic [7:0] tx_i,          // byte to send
    input wire logic last_i,              // release select after this byte
    input wire logic cs_sel_i,            // 0 flash select, 1 aux select
    input wire logic miso_i,              // flash read data
    output lsp_spi_pins_t pins_o,         // port pins
    output logic [7:0] rx_o,              // last byte received
    output logic done_o,                  // one-cycle byte end pulse
    output logic idle_o                   // shifter idle
);
    typedef enum logic [1:0] {SP_IDLE, SP_LOW, SP_HIGH} lsp_sp_state_t;
    lsp_sp_state_t state_reg, state_next;
    logic [1:0] div_reg, div_next;
    logic [2:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next, rx_reg, rx_next;
    logic last_reg, last_next, done_reg, done_next;
    lsp_spi_pins_t pins_reg, pins_next;
    logic tick;

    // ************************************************************
    // shift sequencing
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        rx_next = rx_reg;
        last_next = last_reg;
        pins_next = pins_reg;
        done_next = 1'b0;
        tick = (div_reg == SPI_HALF_LAST);
        div_next = (state_reg == SP_IDLE || tick) ? 2'h0 : div_reg + 2'h1;
        unique case (state_reg)
            SP_IDLE: begin
                if (start_i) begin
                    sh_next = tx_i;
                    bit_next = SPI_MSB;
                    last_next = last_i;
                    pins_next.sclk = 1'b0;
                    pins_next.mosi = tx_i[7];
                    pins_next.cs0_n = cs_sel_i;
                    pins_next.cs1_n = ~cs_sel_i;
                    state_next = SP_LOW;
                end
            end
            SP_LOW: begin
                if (tick) begin
                    pins_next.sclk = 1'b1;
                    sh_next = {sh_reg[6:0], miso_i};
                    state_next = SP_HIGH;
                end
            end
            SP_HIGH: begin
                if (tick) begin
                    pins_next.sclk = 1'b0;
                    if (bit_reg == 3'h0) begin
                        done_next = 1'b1;
                        rx_next = sh_reg;
                        if (last_reg) begin
                            pins_next.cs0_n = 1'b1;
                            pins_next.cs1_n = 1'b1;
                        end
                        state_next = SP_IDLE;
                    end else begin
                        bit_next = bit_reg - 3'h1;
                        pins_next.mosi = sh_reg[7];
                        state_next = SP_LOW;
                    end
                end
            end
        endcase
    end

    // registers
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            state_reg <= SP_IDLE;
            div_reg <= 2'h0;
            bit_reg <= 3'h0;
            sh_reg <= 8'h00;
            rx_reg <= 8'h00;
            last_reg <= 1'b0;
            done_reg <= 1'b0;
            pins_reg <= '{sclk: 1'b0, mosi: 1'b0, cs0_n: 1'b1, cs1_n: 1'b1};
        end else begin
            state_reg <= state_next;
            div_reg <= div_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            rx_reg <= rx_next;
            last_reg <= last_next;
            done_reg <= done_next;
            pins_reg <= pins_next;
        end
    end

    assign pins_o = pins_reg;
    assign rx_o = rx_reg;
    assign done_o = done_reg;
    assign idle_o = (state_reg == SP_IDLE);
endmodule
`default_nettype wire

// *** rtl/lsp_pins.sv ***
// led colour select, host notification, flash port, control port and thermistor converter
//
// Notes on behaviour
// - The led colour select outputs follow the mirror sequence with 00 none, 01 red, 10 green, 11 blue.
// - Both led colour select outputs are low while reset is held.
// - The led outputs stay low through auto-initialisation and follow the sequence only after it.
// - The host notification line shows initialisation in progress and marks its completion.
// - The host notification line is not driven while reset is held.
// - The device masters serial port 0, driving clock and data and pulling the flash select low.
// - A second active-low select exists for an extra peripheral and stays high when unused.
// - Read data from the flash are shifted in as each transfer's received byte.
// - The control port is an i2c slave and the host masters every configuration access on it.
// - The comparator result is taken as the decision bit of a successive approximation.
// - A charge output drives the rc ramp that forms the comparator reference.
`timescale 1ns/10ps
`default_nettype none
module lsp_pins
    import lsp_pkg::*;
(
    input wire logic sys_clk_i,              // core clock, 10 MHz
    input wire logic resetn_i,               // sync reset, active low
    input wire logic seq_valid_i,            // sequencer step strobe
    input wire logic [1:0] seq_colour_i,     // colour of the step
    output logic [1:0] led_colour_select_o,  // bit1..bit0 led select
    output logic host_notify_o,              // notification level
    output logic host_notify_oe_o,           // notification driven
    output logic init_done_o,                // auto-initialisation finished
    output logic [7:0] init_data_o,          // boot byte read from flash
    output logic init_data_valid_o,          // boot byte strobe
    input wire logic spi_start_i,            // user byte request
    input wire logic [7:0] spi_tx_i,         // user byte to send
    input wire logic spi_last_i,             // release select after byte
    input wire logic spi_cs_sel_i,           // 0 flash, 1 aux
    output logic [7:0] spi_rx_o,             // received byte
    output logic spi_done_o,                 // byte finished pulse
    output logic spi_busy_o,                 // user byte in flight
    output lsp_spi_pins_t flash_pins_o,      // serial port 0 pins
    input wire logic flash_read_in_i,        // flash data out
    input wire logic control_port_scl_i,     // control port clock line
    input wire logic control_port_sda_i,     // control port data line
    input wire logic ctrl_sda_pull_i,        // slave engine pulls data low
    output logic control_port_sda_o,         // data drive value
    output logic control_port_sda_oe_o,      // data pulled low
    output lsp_i2c_lines_t ctrl_lines_o,     // sampled lines to slave engine
    input wire logic adc_start_i,            // begin a conversion
    input wire logic comparator_result_in_i, // comparator decision
    output logic ramp_charge_out_o,          // rc ramp charge drive
    output logic [7:0] adc_result_o,         // conversion result
    output logic adc_done_o                  // conversion end pulse
);
    // ************************************************************
    // auto-initialisation boot read
    // ************************************************************
    typedef enum logic [1:0] {IN_ISSUE, IN_WAIT, IN_DONE} lsp_in_state_t;
    lsp_in_state_t in_state_reg, in_state_next;
    logic [4:0] idx_reg, idx_next;
    logic [7:0] idata_reg, idata_next;
    logic ivalid_reg, ivalid_next, idone_reg, idone_next;
    logic sp_start, sp_last, sp_sel, sp_done, sp_idle;
    logic [7:0] sp_tx, sp_rx;

    // boot sequencer: read command, address, then data bytes
    always_comb begin
        in_state_next = in_state_reg;
        idx_next = idx_reg;
        idata_next = idata_reg;
        ivalid_next = 1'b0;
        idone_next = idone_reg;
        unique case (in_state_reg)
            IN_ISSUE: in_state_next = IN_WAIT;
            IN_WAIT: begin
                if (sp_done) begin
                    if (idx_reg > FLASH_ADDR_BYTES) begin
                        idata_next = sp_rx;
                        ivalid_next = 1'b1;
                    end
                    if (idx_reg == INIT_LAST) begin
                        in_state_next = IN_DONE;
                        idone_next = 1'b1;
                    end else begin
                        idx_next = idx_reg + 5'h01;
                        in_state_next = IN_ISSUE;
                    end
                end
            end
            IN_DONE: idone_next = 1'b1;
        endcase
    end

    // registers
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            in_state_reg <= IN_ISSUE;
            idx_reg <= 5'h00;
            idata_reg <= 8'h00;
            ivalid_reg <= 1'b0;
            idone_reg <= 1'b0;
        end else begin
            in_state_reg <= in_state_next;
            idx_reg <= idx_next;
            idata_reg <= idata_next;
            ivalid_reg <= ivalid_next;
            idone_reg <= idone_next;
        end
    end

    // ************************************************************
    // serial port 0 shared between boot and user
    // ************************************************************
    logic ubusy_reg, ubusy_next, udone_reg, udone_next;
    logic [7:0] urx_reg, urx_next;
    logic user_go;

    // user requests accepted only after boot and while nothing in flight
    always_comb begin
        user_go = idone_reg && spi_start_i && !ubusy_reg && sp_idle;
        sp_start = (in_state_reg == IN_ISSUE) || user_go;
        sp_tx = (in_state_reg == IN_ISSUE) ? ((idx_reg == 5'h00) ? FLASH_READ_CMD : 8'h00) : spi_tx_i;
        sp_last = (in_state_reg == IN_ISSUE) ? (idx_reg == INIT_LAST) : spi_last_i;
        sp_sel = (in_state_reg == IN_ISSUE) ? 1'b0 : spi_cs_sel_i;
        ubusy_next = ubusy_reg;
        urx_next = urx_reg;
        udone_next = 1'b0;
        if (user_go) begin
            ubusy_next = 1'b1;
        end else if (ubusy_reg && sp_done) begin
            ubusy_next = 1'b0;
            udone_next = 1'b1;
            urx_next = sp_rx;
        end
    end

    // registers
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ubusy_reg <= 1'b0;
            udone_reg <= 1'b0;
            urx_reg <= 8'h00;
        end else begin
            ubusy_reg <= ubusy_next;
            udone_reg <= udone_next;
            urx_reg <= urx_next;
        end
    end

    lsp_spi_shift u_spi (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .start_i(sp_start),
        .tx_i(sp_tx),
        .last_i(sp_last),
        .cs_sel_i(sp_sel),
        .miso_i(flash_read_in_i),
        .pins_o(flash_pins_o),
        .rx_o(sp_rx),
        .done_o(sp_done),
        .idle_o(sp_idle)
    );

    // ************************************************************
    // led select, notification and control port lines
    // ************************************************************
    logic [1:0] led_reg, led_next;
    logic nval_reg, nval_next, noe_reg, noe_next, sda_oe_reg, sda_oe_next;
    lsp_i2c_lines_t lines_reg, lines_next;

    always_comb begin
        led_next = led_reg;
        if (!idone_reg) begin
            led_next = LED_NONE;
        end else if (seq_valid_i) begin
            led_next = seq_colour_i;
        end
        noe_next = 1'b1;
        nval_next = idone_next ? NOTIFY_DONE : NOTIFY_BUSY;
        lines_next = '{scl: control_port_scl_i, sda: control_port_sda_i};
        sda_oe_next = ctrl_sda_pull_i;
    end

    // registers
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            led_reg <= LED_NONE;
            noe_reg <= 1'b0;
            nval_reg <= NOTIFY_BUSY;
            lines_reg <= '{scl: 1'b1, sda: 1'b1};
            sda_oe_reg <= 1'b0;
        end else begin
            led_reg <= led_next;
            noe_reg <= noe_next;
            nval_reg <= nval_next;
            lines_reg <= lines_next;
            sda_oe_reg <= sda_oe_next;
        end
    end

    // ************************************************************
    // thermistor successive approximation converter
    // ************************************************************
    typedef enum logic {AD_IDLE, AD_RUN} lsp_ad_state_t;
    lsp_ad_state_t ad_state_reg, ad_state_next;
    logic [7:0] code_reg, code_next, pwm_reg, pwm_next, res_reg, res_next;
    logic [2:0] abit_reg, abit_next;
    logic [1:0] settle_reg, settle_next;
    logic chg_reg, chg_next, adone_reg, adone_next, cmp_reg;

    always_comb begin
        ad_state_next = ad_state_reg;
        code_next = code_reg;
        abit_next = abit_reg;
        res_next = res_reg;
        adone_next = 1'b0;
        pwm_next = pwm_reg;
        settle_next = settle_reg;
        chg_next = 1'b0;
        unique case (ad_state_reg)
            AD_IDLE: begin
                if (adc_start_i) begin
                    code_next = ADC_FIRST_TRIAL;
                    abit_next = ADC_MSB;
                    pwm_next = 8'h00;
                    settle_next = 2'h0;
                    ad_state_next = AD_RUN;
                end
            end
            AD_RUN: begin
                chg_next = (pwm_next < code_next);
                pwm_next = pwm_reg + 8'h01;
                if (pwm_reg == PWM_LAST) begin
                    settle_next = settle_reg + 2'h1;
                    if (settle_reg == ADC_SETTLE_LAST) begin
                        if (!cmp_reg) begin
                            code_next[abit_reg] = 1'b0;
                        end
                        if (abit_reg == 3'h0) begin
                            res_next = code_next;
                            adone_next = 1'b1;
                            ad_state_next = AD_IDLE;
                            chg_next = 1'b0;
                        end else begin
                            abit_next = abit_reg - 3'h1;
                            code_next[abit_next] = 1'b1;
                        end
                    end
                end
            end
        endcase
    end

    // registers
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ad_state_reg <= AD_IDLE;
            code_reg <= 8'h00;
            pwm_reg <= 8'h00;
            res_reg <= 8'h00;
            abit_reg <= 3'h0;
            settle_reg <= 2'h0;
            chg_reg <= 1'b0;
            adone_reg <= 1'b0;
            cmp_reg <= 1'b0;
        end else begin
            ad_state_reg <= ad_state_next;
            code_reg <= code_next;
            pwm_reg <= pwm_next;
            res_reg <= res_next;
            abit_reg <= abit_next;
            settle_reg <= settle_next;
            chg_reg <= chg_next;
            adone_reg <= adone_next;
            cmp_reg <= comparator_result_in_i;
        end
    end

    // outputs
    assign led_colour_select_o = led_reg;
    assign host_notify_o = nval_reg;
    assign host_notify_oe_o = noe_reg;
    assign init_done_o = idone_reg;
    assign init_data_o = idata_reg;
    assign init_data_valid_o = ivalid_reg;
    assign spi_rx_o = urx_reg;
    assign spi_done_o = udone_reg;
    assign spi_busy_o = ubusy_reg;
    assign control_port_sda_o = 1'b0;
    assign control_port_sda_oe_o = sda_oe_reg;
    assign ctrl_lines_o = lines_reg;
    assign ramp_charge_out_o = chg_reg;
    assign adc_result_o = res_reg;
    assign adc_done_o = adone_reg;
endmodule
`default_nettype wire

// *** verification/lsp_flash_model.sv ***
// behavioural serial flash on port 0
`timescale 1ns/10ps
`default_nettype none
module lsp_flash_model (
    input wire logic sclk_i,   // serial clock
    input wire logic mosi_i,   // data from device
    input wire logic cs_n_i,   // any select, low
    output logic miso_o,       // data to device
    output logic [7:0] got_o,  // last byte taken
    output int got_n_o         // bytes taken
);
    logic [2:0] bit_n = 3'h0;
    logic [7:0] idx = 8'h00;
    logic [7:0] sh = 8'h00;
    logic [7:0] pat = 8'h00;
    logic bit_v = 1'b0;
    initial got_o = 8'h00;
    initial got_n_o = 0;
    // released line shows inverse of last bit
    assign miso_o = cs_n_i ? ~bit_v : bit_v;
    // take one bit per rising clock
    always @(posedge sclk_i) begin
        if (!cs_n_i) begin
            sh = {sh[6:0], mosi_i};
            bit_n = bit_n + 3'h1;
            if (bit_n == 3'h0) begin
                got_o = sh;
                idx = idx + 8'h01;
                got_n_o = got_n_o + 1;
            end
        end
    end
    always @(negedge cs_n_i) begin
        bit_n = 3'h0;
        idx = 8'h00;
        pat = 8'h5a;
        bit_v = pat[7];
    end
    always @(negedge sclk_i) begin
        pat = 8'h5a ^ idx;
        if (!cs_n_i) bit_v = pat[3'h7 - bit_n];
    end
endmodule
`default_nettype wire

// *** verification/lsp_pins_monitor.sv ***
// assertion checker on the pin block ports
`timescale 1ns/10ps
`default_nettype none
module lsp_pins_monitor
    import lsp_pkg::*;
(
    input wire logic sys_clk_i,                 // clock
    input wire logic resetn_i,                  // reset
    input wire logic seq_valid_i,               // step
    input wire logic [1:0] seq_colour_i,        // colour
    input wire logic [1:0] led_colour_select_o, // led
    input wire logic host_notify_o,             // notify
    input wire logic host_notify_oe_o,          // driven
    input wire logic init_done_o,               // booted
    input wire logic spi_start_i,               // request
    input wire logic spi_cs_sel_i,              // select
    input wire logic spi_busy_o,                // busy
    input wire logic spi_done_o,                // done
    input wire lsp_spi_pins_t flash_pins_o,     // pins
    input wire logic control_port_scl_i,        // scl
    input wire logic control_port_sda_i,        // sda
    input wire logic ctrl_sda_pull_i,           // pull
    input wire logic control_port_sda_o,        // sda value
    input wire logic control_port_sda_oe_o,     // sda drive
    input wire lsp_i2c_lines_t ctrl_lines_o,    // sampled
    input wire logic adc_start_i,               // start
    input wire logic adc_done_o                 // end
);
    logic adc_run_reg;
    logic [13:0] adc_cnt_reg;
    // ****************
    // conversion length
    // ****************
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            adc_run_reg <= 1'b0;
            adc_cnt_reg <= 14'h0;
        end else if (adc_start_i && (!adc_run_reg || adc_done_o)) begin
            adc_run_reg <= 1'b1;
            adc_cnt_reg <= 14'h1;
        end else begin
            adc_run_reg <= adc_run_reg && !adc_done_o;
            adc_cnt_reg <= adc_cnt_reg + 14'h1;
        end
    end
    // ****************
    // properties
    // ****************
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_take;
        spi_start_i && init_done_o && !spi_busy_o;
    endsequence
    sequence s_frame;
        (spi_busy_o && !(flash_pins_o.cs0_n && flash_pins_o.cs1_n)) [*8];
    endsequence
    a_led_reset: assert property (disable iff (1'b0)
        !resetn_i |=> led_colour_select_o == LED_NONE) else $error("led on in reset");
    a_notify_float: assert property (disable iff (1'b0)
        !resetn_i |=> !host_notify_oe_o) else $error("notify driven in reset");
    a_led_init: assert property (
        !init_done_o |-> led_colour_select_o == LED_NONE) else $error("led on in boot");
    a_led_follow: assert property (
        init_done_o && seq_valid_i |=> led_colour_select_o == $past(seq_colour_i))
        else $error("led colour wrong");
    a_notify_busy: assert property (
        $past(resetn_i) && !init_done_o |-> host_notify_oe_o && host_notify_o == NOTIFY_BUSY)
        else $error("notify not busy");
    a_notify_done: assert property (
        init_done_o |-> host_notify_oe_o && host_notify_o == NOTIFY_DONE ##1 init_done_o)
        else $error("notify not done");
    a_spi_lat: assert property (
        s_take |-> ##34 spi_done_o) else $error("byte end late");
    a_spi_frame: assert property (
        s_take |=> s_frame) else $error("frame broken");
    a_cs_choice: assert property (
        s_take |=> ($past(spi_cs_sel_i) ? flash_pins_o.cs0_n && !flash_pins_o.cs1_n
        : !flash_pins_o.cs0_n && flash_pins_o.cs1_n)) else $error("wrong select");
    a_aux_boot: assert property (
        !init_done_o |-> flash_pins_o.cs1_n) else $error("aux select in boot");
    a_ctrl_lines: assert property (
        $past(resetn_i) |-> ctrl_lines_o == {$past(control_port_scl_i), $past(control_port_sda_i)})
        else $error("control lines wrong");
    a_sda_drive: assert property (
        $past(resetn_i) |-> control_port_sda_oe_o == $past(ctrl_sda_pull_i) && !control_port_sda_o)
        else $error("sda drive wrong");
    a_adc_lat: assert property (
        adc_done_o |-> adc_run_reg && adc_cnt_reg inside {[14'h2000:14'h2002]})
        else $error("conversion length wrong");
endmodule
bind lsp_pins lsp_pins_monitor u_mon (.*);
`default_nettype wire

// *** verification/lsp_pins_tb.sv ***
// bench for the led select and peripheral pin block
`timescale 1ns/10ps
`default_nettype none
module lsp_pins_tb
    import lsp_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic seq_valid_i = 1'b0;
    logic [1:0] seq_colour_i = 2'h0;
    logic spi_start_i = 1'b0, spi_last_i = 1'b0, spi_cs_sel_i = 1'b0, adc_start_i = 1'b0;
    logic [7:0] spi_tx_i = 8'h00;
    logic control_port_scl_i = 1'b1, control_port_sda_i = 1'b1, ctrl_sda_pull_i = 1'b0;
    logic flash_read_in_i, comparator_result_in_i, ramp_charge_out_o, adc_done_o;
    logic [1:0] led_colour_select_o;
    logic host_notify_o, host_notify_oe_o, init_done_o, init_data_valid_o;
    logic spi_done_o, spi_busy_o, control_port_sda_o, control_port_sda_oe_o;
    logic [7:0] init_data_o, spi_rx_o, adc_result_o, got;
    lsp_spi_pins_t flash_pins_o;
    lsp_i2c_lines_t ctrl_lines_o;
    logic [8:0] q_mosi[$];
    logic [7:0] q_init[$], q_rx[$], q_adc[$];
    logic [8:0] e9, acc = 9'h0, v_ramp = 9'h0;
    logic [7:0] therm = 8'h00, pcnt = 8'h00;
    int n_errors = 0, n_compared = 0, cyc = 0, got_n;

    lsp_pins DUT (.*);
    lsp_flash_model fm (.sclk_i(flash_pins_o.sclk), .mosi_i(flash_pins_o.mosi),
        .cs_n_i(flash_pins_o.cs0_n & flash_pins_o.cs1_n), .miso_o(flash_read_in_i),
        .got_o(got), .got_n_o(got_n));

    always #50 sys_clk_i = ~sys_clk_i;
    // comparator: thermistor against the averaged ramp
    assign comparator_result_in_i = {1'b0, therm} >= v_ramp;
    always @(posedge sys_clk_i) begin
        pcnt <= pcnt + 8'h1;
        acc <= (pcnt == 8'hff) ? 9'h0 : acc + 9'(ramp_charge_out_o);
        if (pcnt == 8'hff) v_ramp <= acc + 9'(ramp_charge_out_o);
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            stop_test();
        end
    end
    // host line traffic on the control port
    always @(negedge sys_clk_i) begin
        {control_port_scl_i, control_port_sda_i, ctrl_sda_pull_i} <= 3'($urandom);
    end
    // ****************
    // checking
    // ****************
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [7:0] pop8(ref logic [7:0] q[$]);
        return q.size() ? q.pop_front() : 8'hxx;
    endfunction
    task automatic stop_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // watchers take the oldest expectation
    always @(negedge sys_clk_i) begin
        if (init_data_valid_o) chk("boot", init_data_o, pop8(q_init));
        if (spi_done_o) chk("rx", spi_rx_o, pop8(q_rx));
        if (adc_done_o) chk("adc", adc_result_o, pop8(q_adc));
    end
    always @(got_n) begin
        e9 = q_mosi.size() ? q_mosi.pop_front() : 9'h0xx;
        if (!e9[8]) chk("mosi", got, e9[7:0]);
    end
    // ****************
    // stimulus
    // ****************
    task automatic do_reset();
        int k;
        resetn_i = 1'b0;
        repeat (8) @(negedge sys_clk_i);
        chk("led rst", led_colour_select_o, 8'h0);
        chk("oe rst", host_notify_oe_o, 8'h0);
        chk("cs1 rst", flash_pins_o.cs1_n, 8'h1);
        q_mosi.push_back(9'h003);
        repeat (3) q_mosi.push_back(9'h000);
        for (k = 4; k < 20; k++) begin
            q_mosi.push_back(9'h100);
            q_init.push_back(8'h5a ^ 8'(k));
        end
        resetn_i = 1'b1;
        @(negedge sys_clk_i);
        chk("busy", {host_notify_oe_o, host_notify_o}, {7'h1, NOTIFY_BUSY});
        for (k = 0; k < 1000 && !init_done_o; k++) begin
            chk("led boot", led_colour_select_o, 8'h0);
            spi_start_i = 1'($urandom);
            seq_valid_i = 1'b1;
            seq_colour_i = 2'($urandom);
            @(negedge sys_clk_i);
        end
        spi_start_i = 1'b0;
        seq_valid_i = 1'b0;
        chk("done", {host_notify_oe_o, host_notify_o}, {7'h1, NOTIFY_DONE});
    endtask
    task automatic xfer(input logic last, input logic sel, input logic [7:0] idx);
        int k;
        spi_tx_i = 8'($urandom);
        spi_last_i = last;
        spi_cs_sel_i = sel;
        spi_start_i = 1'b1;
        q_mosi.push_back({1'b0, spi_tx_i});
        q_rx.push_back(8'h5a ^ idx);
        @(negedge sys_clk_i);
        chk("sel", sel ? flash_pins_o.cs1_n : flash_pins_o.cs0_n, 8'h0);
        for (k = 0; k < 40 && !spi_done_o; k++) begin
            spi_start_i = (k == 5);
            @(negedge sys_clk_i);
        end
        chk("end", spi_done_o, 8'h1);
    endtask
    task automatic conv(input logic [7:0] t);
        int k;
        therm = t;
        q_adc.push_back(t);
        adc_start_i = 1'b1;
        @(negedge sys_clk_i);
        for (k = 0; k < 9000 && !adc_done_o; k++) begin
            adc_start_i = (k == 50);
            @(negedge sys_clk_i);
        end
    endtask
    initial begin
        int i;
        void'($urandom(82107));
        do_reset();
        for (i = 0; i < 4; i++) begin
            seq_valid_i = 1'b1;
            seq_colour_i = 2'(i);
            @(negedge sys_clk_i);
            chk("led", led_colour_select_o, 8'(i));
        end
        seq_valid_i = 1'b0;
        for (i = 0; i < 4; i++) xfer(1'b1, i[0], 8'h0);
        for (i = 0; i < 3; i++) xfer(i == 2, 1'b0, 8'(i));
        chk("cs0", flash_pins_o.cs0_n, 8'h1);
        do_reset();
        conv(8'($urandom));
        conv(8'hff);
        @(negedge sys_clk_i);
        chk("left", 8'(q_mosi.size() + q_init.size() + q_rx.size() + q_adc.size()), 8'h0);
        stop_test();
    end
endmodule
`default_nettype wire
